// ---- bst_tap.sv ----
// boundary-scan test access port: tap controller, instruction and data registers
`timescale 1ns/10ps
module bst_tap
(
   input  wire logic                       clk_sys,
   input  wire logic                       sys_rst,
   input  wire logic                       tck,
   input  wire logic                       tms,
   input  wire logic                       tdi,
   input  wire logic                       trst_n,
   input  wire logic [bst_pkg::BSR_W-1:0]  bsr_core_in,
   output logic                            tdo,
   output logic                            tdo_oe,
   output logic                            tms_pull_en,
   output logic                            tdi_pull_en,
   output logic                            trst_pull_en,
   output logic [bst_pkg::BSR_W-1:0]       bsr_pin_out,
   output logic                            bsr_drive_en
);
   // ***************************************************************
   // pin synchronisation and test clock edges
   // ***************************************************************
   bst_pkg::bst_pins_s pin_a;
   bst_pkg::bst_pins_s pin_s;
   bst_pkg::bst_state_s st_q;
   bst_pkg::bst_state_s st_d;
   logic                tck_rise;
   logic                tck_fall;
   bst_pkg::bst_sel_e   dr_sel;

   assign pin_a = '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};

   bst_sync u_sync
   (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .pin_a   (pin_a),
      .pin_s   (pin_s)
   );

   // edges of the sampled test clock; core timing never gates these
   assign tck_rise = pin_s.tck & ~st_q.tck_p;
   assign tck_fall = ~pin_s.tck & st_q.tck_p;

   // ***************************************************************
   // instruction decode
   // ***************************************************************
   // unknown codes fall back to bypass, keeping the chain one bit long
   always_comb
   begin
      unique case (st_q.ir)
         bst_pkg::INS_IDCODE: dr_sel = bst_pkg::SEL_ID;
         bst_pkg::INS_EXTEST: dr_sel = bst_pkg::SEL_BSR;
         bst_pkg::INS_SAMPLE: dr_sel = bst_pkg::SEL_BSR;
         default:             dr_sel = bst_pkg::SEL_BYPASS;
      endcase
   end

   // ***************************************************************
   // tap state sequence
   // ***************************************************************
   function automatic bst_pkg::bst_tap_e tap_next
   (
      input bst_pkg::bst_tap_e s,
      input logic              m
   );
      unique case (s)
         bst_pkg::TAP_RESET:  tap_next = m ? bst_pkg::TAP_RESET  : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_IDLE:   tap_next = m ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_SEL_DR: tap_next = m ? bst_pkg::TAP_SEL_IR : bst_pkg::TAP_CAP_DR;
         bst_pkg::TAP_CAP_DR: tap_next = m ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
         bst_pkg::TAP_SH_DR:  tap_next = m ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
         bst_pkg::TAP_EX1_DR: tap_next = m ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_PA_DR;
         bst_pkg::TAP_PA_DR:  tap_next = m ? bst_pkg::TAP_EX2_DR : bst_pkg::TAP_PA_DR;
         bst_pkg::TAP_EX2_DR: tap_next = m ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_SH_DR;
         bst_pkg::TAP_UPD_DR: tap_next = m ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_SEL_IR: tap_next = m ? bst_pkg::TAP_RESET  : bst_pkg::TAP_CAP_IR;
         bst_pkg::TAP_CAP_IR: tap_next = m ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
         bst_pkg::TAP_SH_IR:  tap_next = m ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
         bst_pkg::TAP_EX1_IR: tap_next = m ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_PA_IR;
         bst_pkg::TAP_PA_IR:  tap_next = m ? bst_pkg::TAP_EX2_IR : bst_pkg::TAP_PA_IR;
         bst_pkg::TAP_EX2_IR: tap_next = m ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_SH_IR;
         bst_pkg::TAP_UPD_IR: tap_next = m ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_IDLE;
      endcase
   endfunction

   // ***************************************************************
   // next state of the whole port
   // ***************************************************************
   always_comb
   begin
      st_d         = st_q;
      st_d.tck_p   = pin_s.tck;
      st_d.pull_en = 1'b1;
      if (!pin_s.trst_n)
      begin
         // pin reset wins over any edge in the same cycle
         st_d.tap    = bst_pkg::TAP_RESET;
         st_d.ir     = bst_pkg::INS_IDCODE;
         st_d.ir_sh  = bst_pkg::IR_CAPTURE;
         st_d.extest = 1'b0;
         st_d.tdo_oe = 1'b0;
      end
      else if (tck_rise)
      begin
         if (st_q.tap == bst_pkg::TAP_RESET)
         begin
            st_d.ir     = bst_pkg::INS_IDCODE;
            st_d.extest = 1'b0;
         end
         else if (st_q.tap == bst_pkg::TAP_CAP_IR)
            st_d.ir_sh = bst_pkg::IR_CAPTURE;
         else if (st_q.tap == bst_pkg::TAP_SH_IR)
            st_d.ir_sh = {pin_s.tdi, st_q.ir_sh[bst_pkg::IR_W-1:1]};
         else if (st_q.tap == bst_pkg::TAP_UPD_IR)
         begin
            st_d.ir     = st_q.ir_sh;
            st_d.extest = (st_q.ir_sh == bst_pkg::INS_EXTEST);
         end
         else if (st_q.tap == bst_pkg::TAP_CAP_DR)
         begin
            if (dr_sel == bst_pkg::SEL_ID)
               st_d.dr_sh = bst_pkg::ID_VALUE;
            else if (dr_sel == bst_pkg::SEL_BSR)
               st_d.dr_sh[bst_pkg::BSR_W-1:0] = bsr_core_in;
            else
               st_d.dr_sh[0] = 1'b0;
         end
         else if (st_q.tap == bst_pkg::TAP_SH_DR)
         begin
            if (dr_sel == bst_pkg::SEL_ID)
               st_d.dr_sh = {pin_s.tdi, st_q.dr_sh[bst_pkg::DR_W-1:1]};
            else if (dr_sel == bst_pkg::SEL_BSR)
               st_d.dr_sh[bst_pkg::BSR_W-1:0] =
                  {pin_s.tdi, st_q.dr_sh[bst_pkg::BSR_W-1:1]};
            else
               st_d.dr_sh[0] = pin_s.tdi;
         end
         else if (st_q.tap == bst_pkg::TAP_UPD_DR && dr_sel == bst_pkg::SEL_BSR)
            st_d.bsr_upd = st_q.dr_sh[bst_pkg::BSR_W-1:0];
         st_d.tap = tap_next(st_q.tap, pin_s.tms);
      end
      else if (tck_fall)
      begin
         // driver turns on only for the shift states
         st_d.tdo_oe = (st_q.tap == bst_pkg::TAP_SH_IR) ||
                       (st_q.tap == bst_pkg::TAP_SH_DR);
         if (st_q.tap == bst_pkg::TAP_SH_IR)
            st_d.tdo = st_q.ir_sh[0];
         else if (st_q.tap == bst_pkg::TAP_SH_DR)
            st_d.tdo = st_q.dr_sh[0];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         st_q <= bst_pkg::ST_RST;
      else
         st_q <= st_d;
   end

   assign tdo          = st_q.tdo;
   assign tdo_oe       = st_q.tdo_oe;
   assign tms_pull_en  = st_q.pull_en;
   assign tdi_pull_en  = st_q.pull_en;
   assign trst_pull_en = st_q.pull_en;
   assign bsr_pin_out  = st_q.bsr_upd;
   assign bsr_drive_en = st_q.extest;

   // ***************************************************************
   // checks
   // ***************************************************************
   logic [2:0] tms_hi_cnt;

   // counts rising edges with tms high in a row, saturating
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst || !pin_s.trst_n)
         tms_hi_cnt <= 3'h0;
      else if (tck_rise)
         tms_hi_cnt <= pin_s.tms ? ((tms_hi_cnt == 3'h7) ? 3'h7 : tms_hi_cnt + 3'h1) : 3'h0;
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   chk_five_tms_reset: assert property (
      tck_rise && pin_s.trst_n && pin_s.tms
      && tms_hi_cnt >= 3'(bst_pkg::TMS_RST_EDGES - 1)
      |=> st_q.tap == bst_pkg::TAP_RESET)
      else $error("five tms-high edges did not reach reset");

   chk_trst_clears: assert property (
      !pin_s.trst_n |=> st_q.tap == bst_pkg::TAP_RESET && st_q.ir == bst_pkg::INS_IDCODE
      && !st_q.tdo_oe)
      else $error("test reset did not clear tap and instruction");

   chk_tdo_on_fall: assert property (
      $changed(st_q.tdo) |-> $past(tck_fall))
      else $error("tdo changed away from a falling edge");

   chk_oe_shift_only: assert property (
      $rose(st_q.tdo_oe) |-> $past(st_q.tap == bst_pkg::TAP_SH_IR
      || st_q.tap == bst_pkg::TAP_SH_DR))
      else $error("tdo driver enabled outside a shift state");

   chk_oe_off_idle: assert property (
      tck_fall && st_q.tap == bst_pkg::TAP_IDLE && pin_s.trst_n |=> !st_q.tdo_oe)
      else $error("tdo driver left on while idle");

   chk_tap_on_rise: assert property (
      $changed(st_q.tap) |-> $past(tck_rise || !pin_s.trst_n))
      else $error("tap state moved without a rising test clock");

   chk_ir_shift_in: assert property (
      tck_rise && pin_s.trst_n && st_q.tap == bst_pkg::TAP_SH_IR
      |=> st_q.ir_sh[3] == $past(pin_s.tdi) && st_q.ir_sh[2:0] == $past(st_q.ir_sh[3:1]))
      else $error("instruction shift lost a bit");

   chk_ir_update: assert property (
      tck_rise && pin_s.trst_n && st_q.tap == bst_pkg::TAP_UPD_IR
      |=> st_q.ir == $past(st_q.ir_sh))
      else $error("instruction not updated from shift stage");

   chk_id_capture: assert property (
      tck_rise && pin_s.trst_n && st_q.tap == bst_pkg::TAP_CAP_DR
      && st_q.ir == bst_pkg::INS_IDCODE |=> st_q.dr_sh == bst_pkg::ID_VALUE && st_q.dr_sh[0])
      else $error("identification capture wrong");

   chk_bypass_one_bit: assert property (
      tck_rise && pin_s.trst_n && st_q.tap == bst_pkg::TAP_SH_DR
      && st_q.ir == bst_pkg::INS_BYPASS
      |=> st_q.dr_sh[0] == $past(pin_s.tdi) ##1 st_q.dr_sh[31:1] == $past(st_q.dr_sh[31:1], 2))
      else $error("bypass path is not one bit");

   chk_bsr_update: assert property (
      tck_rise && pin_s.trst_n && st_q.tap == bst_pkg::TAP_UPD_DR && dr_sel == bst_pkg::SEL_BSR
      |=> st_q.bsr_upd == $past(st_q.dr_sh[7:0]))
      else $error("boundary update stage not loaded");

   chk_pull_on: assert property (
      st_q.pull_en && tms_pull_en && tdi_pull_en && trst_pull_en)
      else $error("input pull-up released");

   chk_ir_capture: assert property (
      tck_rise && pin_s.trst_n && st_q.tap == bst_pkg::TAP_CAP_IR
      |=> st_q.ir_sh == bst_pkg::IR_CAPTURE)
      else $error("instruction capture value wrong");

   chk_tdo_dr_bit: assert property (
      tck_fall && pin_s.trst_n && st_q.tap == bst_pkg::TAP_SH_DR
      |=> st_q.tdo == $past(st_q.dr_sh[0]) && st_q.tdo_oe)
      else $error("tdo did not present the data shift bit");

   chk_bsr_capture: assert property (
      tck_rise && pin_s.trst_n && st_q.tap == bst_pkg::TAP_CAP_DR && dr_sel == bst_pkg::SEL_BSR
      |=> st_q.dr_sh[7:0] == $past(bsr_core_in))
      else $error("boundary capture did not take core values");

   chk_id_shift_in: assert property (
      tck_rise && pin_s.trst_n && st_q.tap == bst_pkg::TAP_SH_DR && dr_sel == bst_pkg::SEL_ID
      |=> st_q.dr_sh == {$past(pin_s.tdi), $past(st_q.dr_sh[31:1])})
      else $error("identification shift lost a bit");

   chk_drive_extest: assert property (
      tck_rise && pin_s.trst_n && st_q.tap == bst_pkg::TAP_UPD_IR
      |=> bsr_drive_en == ($past(st_q.ir_sh) == bst_pkg::INS_EXTEST))
      else $error("boundary drive enable does not follow extest");

   chk_dr_on_rise: assert property (
      $changed(st_q.dr_sh) |-> $past(tck_rise))
      else $error("data register moved without a rising test clock");

   cov_id_read: cover property (
      st_q.ir == bst_pkg::INS_IDCODE && st_q.tap == bst_pkg::TAP_SH_DR && st_q.tdo_oe);

   cov_bypass_shift: cover property (
      st_q.ir == bst_pkg::INS_BYPASS && st_q.tap == bst_pkg::TAP_SH_DR && tck_fall);

   cov_extest_on: cover property ($rose(st_q.extest));

   cov_tms_reset: cover property (
      st_q.tap == bst_pkg::TAP_SH_DR ##[1:1000] st_q.tap == bst_pkg::TAP_RESET && pin_s.trst_n);

endmodule

// ---- bst_pkg.sv ----
// shared package for the boundary-scan test port and its pin synchroniser
// ***************************************************************
// shared constants and carriers
// ***************************************************************
package bst_pkg;

   localparam int IR_W     = 4;
   localparam int DR_W     = 32;
   localparam int BSR_W    = 8;
   localparam int PIN_W    = 4;
   localparam int TMS_RST_EDGES = 5;

   // instruction codes
   localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
   localparam logic [IR_W-1:0] INS_SAMPLE = 4'h1;
   localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
   localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

   // identification fields; values are arbitrary
   localparam logic [3:0]  ID_VERSION = 4'h1;
   localparam logic [15:0] ID_PART    = 16'h5A5A;
   localparam logic [10:0] ID_MFR     = 11'h07E;
   localparam int ID_VER_POS  = 28;
   localparam int ID_PART_POS = 12;
   localparam int ID_MFR_POS  = 1;
   localparam logic [DR_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE,
      TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR,
      TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
   } bst_tap_e;

   typedef enum logic [1:0] {SEL_BYPASS, SEL_ID, SEL_BSR} bst_sel_e;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } bst_pins_s;

   typedef struct packed {
      logic [PIN_W-1:0] meta;
      logic [PIN_W-1:0] sync;
   } bst_sync_s;

   typedef struct packed {
      bst_tap_e              tap;
      logic                  tck_p;
      logic [IR_W-1:0]       ir_sh;
      logic [IR_W-1:0]       ir;
      logic [DR_W-1:0]       dr_sh;
      logic [BSR_W-1:0]      bsr_upd;
      logic                  extest;
      logic                  tdo;
      logic                  tdo_oe;
      logic                  pull_en;
   } bst_state_s;

   // tck rests low; the other pins idle high, as the pull-ups leave them
   // a high reset value on tck would fake a rising edge right after reset
   localparam bst_sync_s SYNC_RST = '{meta: 4'h7, sync: 4'h7};

   localparam bst_state_s ST_RST = '{
      tap:     TAP_RESET,
      tck_p:   1'b0,
      ir_sh:   IR_CAPTURE,
      ir:      INS_IDCODE,
      dr_sh:   32'h0000_0000,
      bsr_upd: 8'h00,
      extest:  1'b0,
      tdo:     1'b0,
      tdo_oe:  1'b0,
      pull_en: 1'b1
   };

endpackage

// ---- bst_sync.sv ----
// two-flop synchroniser for the test pins
`timescale 1ns/10ps
module bst_sync
(
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   input  wire bst_pkg::bst_pins_s pin_a,
   output bst_pkg::bst_pins_s      pin_s
);
   bst_pkg::bst_sync_s st_q;
   bst_pkg::bst_sync_s st_d;

   // first stage feeds only the second stage
   always_comb
   begin
      st_d      = st_q;
      st_d.meta = pin_a;
      st_d.sync = st_q.meta;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         st_q <= bst_pkg::SYNC_RST;
      else
         st_q <= st_d;
   end

   assign pin_s = st_q.sync;

endmodule

// ---- bst_ctl_model.sv ----
// behavioural outside test controller driving the scan pins
`timescale 1ns/10ps
module bst_ctl_model
(
   input  wire logic clk_sys,
   input  wire logic tdo,
   input  wire logic tdo_oe,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trst_n,
   output logic      pin_en,
   output logic      cap_stb,
   output logic      cap_tdo,
   output logic      cap_oe
);
   initial
   begin
      tck     = 1'b0;
      tms     = 1'b1;
      tdi     = 1'b1;
      trst_n  = 1'b1;
      pin_en  = 1'b1;
      cap_stb = 1'b0;
      cap_tdo = 1'b0;
      cap_oe  = 1'b0;
   end

   // ***************************************************************
   // test clock periods and pin control
   // ***************************************************************
   // one 125 ns period; tck rests low between calls, so no free-running clock
   task automatic step(input logic m, input logic d, input logic want);
      @(negedge clk_sys);
      tms <= m;
      tdi <= d;
      repeat (12) @(negedge clk_sys);
      tck     <= 1'b1;
      // undriven tdo is not trusted: the controller sees a changing level
      cap_tdo <= tdo_oe ? tdo : ~cap_tdo;
      cap_oe  <= tdo_oe;
      cap_stb <= want;
      @(negedge clk_sys);
      cap_stb <= 1'b0;
      repeat (11) @(negedge clk_sys);
      tck <= 1'b0;
   endtask

   task automatic trst_pulse;
      @(negedge clk_sys);
      trst_n <= 1'b0;
      repeat (6) @(negedge clk_sys);
      trst_n <= 1'b1;
      repeat (4) @(negedge clk_sys);
   endtask

   task automatic float_pins(input logic r);
      @(negedge clk_sys);
      pin_en <= ~r;
   endtask
endmodule

// ---- tb_top.sv ----
// self-checking testbench for the boundary-scan test port
`timescale 1ns/10ps
module tb_top;
   logic       clk_sys = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:0] core_in = 8'h00;
   logic [7:0] rnd     = 8'h48;
   logic       tck, tms_o, tdi_o, trst_n, pin_en, cap_stb, cap_tdo, cap_oe;
   logic       tms_w, tdi_w, tdo, tdo_oe, tms_pu, tdi_pu, trst_pu, drive_en;
   logic [7:0] pin_out;
   logic [1:0] exp_q [$];
   int         error_cnt = 0;
   int         tests_run = 0;
   localparam logic [31:0] ID_EXP = {bst_pkg::ID_VERSION, bst_pkg::ID_PART,
                                     bst_pkg::ID_MFR, 1'b1};
   logic [3:0] ins_tab [5] = '{bst_pkg::INS_EXTEST, bst_pkg::INS_SAMPLE,
                               bst_pkg::INS_BYPASS, 4'h5, bst_pkg::INS_IDCODE};

   always #2.5 clk_sys = ~clk_sys;

   // released pins fall to the pull level, or to the inverse of the driven level without one
   assign tms_w = pin_en ? tms_o : (tms_pu ? 1'b1 : ~tms_o);
   assign tdi_w = pin_en ? tdi_o : (tdi_pu ? 1'b1 : ~tdi_o);

   bst_ctl_model ctl_u (.clk_sys(clk_sys), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck),
      .tms(tms_o), .tdi(tdi_o), .trst_n(trst_n), .pin_en(pin_en), .cap_stb(cap_stb),
      .cap_tdo(cap_tdo), .cap_oe(cap_oe));

   bst_tap dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .tck(tck), .tms(tms_w),
      .tdi(tdi_w), .trst_n(trst_n), .bsr_core_in(core_in), .tdo(tdo), .tdo_oe(tdo_oe),
      .tms_pull_en(tms_pu), .tdi_pull_en(tdi_pu), .trst_pull_en(trst_pu),
      .bsr_pin_out(pin_out), .bsr_drive_en(drive_en));

   // ***************************************************************
   // compare, report and close
   // ***************************************************************
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (e !== s)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic finish_test;
      if (exp_q.size() != 0)
      begin
         error_cnt++;
      end
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // watcher: every captured tdo bit takes the oldest note
   always @(posedge clk_sys)
   begin
      if (cap_stb === 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            check("tdo note", 32'h0000_0001, 32'h0000_0000);
         end
         else
         begin
            logic [1:0] e;
            e = exp_q.pop_front();
            check("tdo_oe", 32'(e[1]), 32'(cap_oe));
            if (e[1])
            begin
               check("tdo", 32'(e[0]), 32'(cap_tdo));
            end
         end
      end
   end

   // ***************************************************************
   // scan helpers
   // ***************************************************************
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // from idle through capture and shift, then update and back to idle
   task automatic scan(input bit ir, input int n, input logic [31:0] din,
                       input logic [31:0] ex);
      ctl_u.step(1'b1, 1'b0, 1'b0);
      if (ir)
      begin
         ctl_u.step(1'b1, 1'b0, 1'b0);
      end
      ctl_u.step(1'b0, 1'b0, 1'b0);
      ctl_u.step(1'b0, 1'b0, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         exp_q.push_back({1'b1, ex[i]});
         ctl_u.step(i == n - 1, din[i], 1'b1);
      end
      // driver must be off again once shifting has stopped
      exp_q.push_back(2'h0);
      ctl_u.step(1'b1, 1'b0, 1'b1);
      ctl_u.step(1'b0, 1'b0, 1'b0);
   endtask

   task automatic to_idle;
      repeat (5) ctl_u.step(1'b1, 1'b0, 1'b0);
      ctl_u.step(1'b0, 1'b0, 1'b0);
   endtask

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      repeat (3) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys);
      check("pulls", 32'h0000_0007, 32'({tms_pu, tdi_pu, trst_pu}));
      check("bsr_drive_en", 32'h0000_0000, 32'(drive_en));
      to_idle();
      scan(1'b0, 32, 32'h0000_0000, ID_EXP);
      foreach (ins_tab[k])
      begin
         logic [3:0] ins;
         ins = ins_tab[k];
         scan(1'b1, 4, 32'(ins), 32'(bst_pkg::IR_CAPTURE));
         rnd = lfsr_next(rnd);
         @(negedge clk_sys);
         core_in = rnd;
         rnd = lfsr_next(rnd);
         if (ins == bst_pkg::INS_EXTEST || ins == bst_pkg::INS_SAMPLE)
         begin
            scan(1'b0, 8, 32'(rnd), 32'(core_in));
            check("bsr_pin_out", 32'(rnd), 32'(pin_out));
            check("bsr_drive_en", 32'(ins == bst_pkg::INS_EXTEST), 32'(drive_en));
         end
         else if (ins == bst_pkg::INS_IDCODE)
         begin
            scan(1'b0, 32, 32'(rnd), ID_EXP);
         end
         else
         begin
            scan(1'b0, 9, {23'h00_0000, rnd[0], rnd}, {23'h00_0000, rnd, 1'b0});
         end
      end
      scan(1'b1, 4, 32'(bst_pkg::INS_BYPASS), 32'(bst_pkg::IR_CAPTURE));
      ctl_u.trst_pulse();
      ctl_u.step(1'b0, 1'b0, 1'b0);
      scan(1'b0, 32, 32'h0000_0000, ID_EXP);
      scan(1'b1, 4, 32'(bst_pkg::INS_BYPASS), 32'(bst_pkg::IR_CAPTURE));
      ctl_u.float_pins(1'b1);
      repeat (5) ctl_u.step(1'b0, 1'b0, 1'b0);
      ctl_u.float_pins(1'b0);
      ctl_u.step(1'b0, 1'b0, 1'b0);
      scan(1'b0, 32, 32'h0000_0000, ID_EXP);
      repeat (20) @(negedge clk_sys);
      finish_test();
   end

   // bounded run: a hang counts as a mismatch
   initial
   begin
      repeat (50000) @(posedge clk_sys);
      error_cnt++;
      finish_test();
   end
endmodule
